// ### design/pum_pkg.sv
// constants, types and carriers for the upper port pin function select
// assumes a single 25 MHz system clock and one async power-on reset

package pum_pkg;

	// -------------------------------------------------------------
	// register offsets on the plain register port
	// -------------------------------------------------------------
	localparam logic [3:0]  PUM_OFS_SEL_ONE = 4'h0;
	localparam logic [3:0]  PUM_OFS_SEL_TWO = 4'h2;
	localparam logic [3:0]  PUM_OFS_EFF_ONE = 4'h4;
	localparam logic [3:0]  PUM_OFS_EFF_TWO = 4'h6;

	// -------------------------------------------------------------
	// field encodings and values after reset
	// -------------------------------------------------------------
	localparam logic [1:0]  PUM_MD_GPIO     = 2'h0;
	localparam logic [1:0]  PUM_MD_DBUS     = 2'h1;
	localparam logic [1:0]  PUM_MD_ALT      = 2'h2;
	localparam logic [1:0]  PUM_MD_RSVD     = 2'h3;
	localparam logic [15:0] PUM_SEL_RESET   = 16'h0000;

	// pins whose alternate function drives the pin (irq ack, cs, dack)
	localparam logic [15:0] PUM_ALT_OUT_MASK = 16'h7C00;
	// pins whose alternate function survives single-chip mode
	localparam logic [15:0] PUM_ALT_SC_MASK  = 16'h80FF;

	// pin positions within the sixteen (index 0 is port pin 16)
	localparam int PUM_PIN_TRIG   = 15;
	localparam int PUM_PIN_IRQACK = 14;
	localparam int PUM_PIN_CS3    = 13;
	localparam int PUM_PIN_CS2    = 12;
	localparam int PUM_PIN_DMA_ACK_ONE  = 11;
	localparam int PUM_PIN_DMA_ACK_ZERO  = 10;
	localparam int PUM_PIN_DMA_REQ_ONE  = 9;
	localparam int PUM_PIN_DMA_REQ_ZERO  = 8;

	// -------------------------------------------------------------
	// types
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		PUM_FN_GPIO = 3'b001,
		PUM_FN_DBUS = 3'b010,
		PUM_FN_ALT  = 3'b100
	} pum_func_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} pum_bus_req_t;

	typedef struct packed {
		logic irq_accept_n;
		logic cs3_n;
		logic cs2_n;
		logic dma_ack_one_n;
		logic dma_ack_zero_n;
	} pum_alt_src_t;

	typedef struct packed {
		logic       trig_n;
		logic [1:0] dreq_n;
		logic [7:0] irq_n;
	} pum_periph_in_t;

	typedef struct packed {
		logic [15:0]    sel_one;
		logic [15:0]    sel_two;
		logic [31:0]    eff;
		logic [15:0]    rdata;
		logic [15:0]    pin_out;
		logic [15:0]    pin_oe_n;
		logic [15:0]    dbus_in;
		pum_periph_in_t periph;
	} pum_state_t;

	localparam pum_state_t PUM_STATE_RESET = '{
		sel_one:  PUM_SEL_RESET,
		sel_two:  PUM_SEL_RESET,
		eff:      32'h0000_0000,
		rdata:    16'h0000,
		pin_out:  16'h0000,
		pin_oe_n: 16'hFFFF,
		dbus_in:  16'h0000,
		periph:   '{trig_n: 1'b1, dreq_n: 2'h3, irq_n: 8'hFF}
	};

endpackage

// ### design/pum_pin_select.sv
// function select for the upper sixteen multiplexed pins of a port
// assumes synchronous inputs on clk_sys; pads resolve pin_out/pin_oe_n
//
// How it works
// R1: two 16-bit read/write select registers choose each upper pin's function
// R2: first register covers pins 31..24, second covers pins 23..16
// R3: the operating mode may override the register fields
// R4: power-on reset clears both select registers to zero
// R5: manual, watchdog, standby and sleep leave the registers untouched
// R6: without the pins the registers still read back what was written
// R7: two bits per pin, highest pin in bits 15:14 down to 1:0
// R8: field 00 gives general input/output under direction and data
// R9: field 01 gives the data bus bit, general I/O in single-chip mode
// R10: rom-less with 32-bit area zero forces every pin onto the data bus
// R11: pin 31 field 10 routes the conversion trigger input
// R12: pin 30 field 10 drives interrupt accepted, reserved in single-chip
// R13: pins 29/28 field 10 drive chip selects three/two, not single-chip
// R14: pins 27/26 field 10 drive dma acks one/zero, not single-chip
// R15: pins 25/24 field 10 route dma requests one/zero, not single-chip
// R16: general I/O pin drives when its direction bit is one
// R17: software never writes 11; such a field acts as general I/O
//
// Added by the designer: the placing of the registers and the plain strobed port.

module pum_pin_select
	import pum_pkg::*;
#(
	parameter bit PINS_PRESENT = 1'b1
) (
	// clock and power-on reset
	input  wire logic           clk_sys,
	input  wire logic           resetn,
	// register port
	input  wire pum_bus_req_t   reg_req,
	output logic [15:0]         reg_rdata,
	// chip operating mode
	input  wire logic           single_chip,
	input  wire logic           romless_cs0_32,
	// general port direction and data
	input  wire logic [15:0]    gpio_dir,
	input  wire logic [15:0]    gpio_data_out,
	// external bus controller, data bits 31..16
	input  wire logic [15:0]    dbus_out,
	input  wire logic           dbus_drive,
	output logic [15:0]         dbus_in,
	// peripheral signals
	input  wire pum_alt_src_t   alt_src,
	output pum_periph_in_t      periph_in,
	// pins, index 0 is port pin 16
	input  wire logic [15:0]    pin_in,
	output logic [15:0]         pin_out,
	output logic [15:0]         pin_oe_n
);

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	pum_state_t  st_ff;
	pum_state_t  nxt_st;

	logic [31:0] cfg;
	logic [15:0] alt_vec;
	logic [15:0] drv_out;
	logic [15:0] drv_oe_n;
	logic [31:0] eff_code;
	logic [15:0] eff_is_dbus;
	pum_func_t   fn [16];

	// both registers as one vector, pin i owns bits 2i+1:2i
	assign cfg = {st_ff.sel_one, st_ff.sel_two}; // see R2 see R7

	// alternate output sources lined up by pin
	assign alt_vec = {1'b1,
		alt_src.irq_accept_n,
		alt_src.cs3_n,
		alt_src.cs2_n,
		alt_src.dma_ack_one_n, // see R13 see R14
		alt_src.dma_ack_zero_n,
		10'h3FF};

	// -------------------------------------------------------------
	// per pin function decode
	// -------------------------------------------------------------
	for (genvar i = 0; i < 16; i++) begin : g_pin
		logic [1:0] md;

		assign md = cfg[2*i +: 2]; // see R7

		// mode override first, then the field; 11 falls to gpio
		assign fn[i] =
			!PINS_PRESENT ? PUM_FN_GPIO : // see R6
			romless_cs0_32 ? PUM_FN_DBUS : // see R10 see R3
			(md == PUM_MD_DBUS && !single_chip) ? PUM_FN_DBUS : // see R9
			(md == PUM_MD_ALT &&
			 (!single_chip || PUM_ALT_SC_MASK[i])) ? PUM_FN_ALT : // see R12
			PUM_FN_GPIO; // see R8 see R17

		// pin drive for the chosen function
		assign drv_out[i] =
			(fn[i] == PUM_FN_DBUS) ? dbus_out[i] :
			(fn[i] == PUM_FN_ALT)  ? alt_vec[i] :
			gpio_data_out[i];

		// gpio drives only when its direction bit is set
		assign drv_oe_n[i] =
			(fn[i] == PUM_FN_DBUS) ? !dbus_drive :
			(fn[i] == PUM_FN_ALT)  ? !PUM_ALT_OUT_MASK[i] : // see R13
			!gpio_dir[i]; // see R16

		// effective function as software sees it
		assign eff_code[2*i +: 2] =
			(fn[i] == PUM_FN_DBUS) ? PUM_MD_DBUS :
			(fn[i] == PUM_FN_ALT)  ? PUM_MD_ALT :
			PUM_MD_GPIO;

		assign eff_is_dbus[i] = (st_ff.eff[2*i +: 2] == PUM_MD_DBUS);
	end

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	// one pass builds every register; read data lives a single cycle
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdata = 16'h0000;

		// writes land even without pins, so software can read back
		if (reg_req.wr) begin
			case (reg_req.addr)
				PUM_OFS_SEL_ONE: nxt_st.sel_one = reg_req.wdata; // see R1
				PUM_OFS_SEL_TWO: nxt_st.sel_two = reg_req.wdata; // see R6
				default: ;
			endcase
		end

		// unmapped reads answer zero
		if (reg_req.rd) begin
			case (reg_req.addr)
				PUM_OFS_SEL_ONE: nxt_st.rdata = st_ff.sel_one; // see R1
				PUM_OFS_SEL_TWO: nxt_st.rdata = st_ff.sel_two;
				PUM_OFS_EFF_ONE: nxt_st.rdata = st_ff.eff[31:16];
				PUM_OFS_EFF_TWO: nxt_st.rdata = st_ff.eff[15:0];
				default:         nxt_st.rdata = 16'h0000;
			endcase
		end

		// registered pads cost one cycle but keep outputs glitch free
		nxt_st.eff      = eff_code;
		nxt_st.pin_out  = drv_out;
		nxt_st.pin_oe_n = drv_oe_n;
		nxt_st.dbus_in  = pin_in;

		// unselected peripheral inputs idle at their inactive high
		nxt_st.periph.trig_n = (fn[PUM_PIN_TRIG] == PUM_FN_ALT) ?
			pin_in[PUM_PIN_TRIG] : 1'b1; // see R11
		nxt_st.periph.dreq_n[1] = (fn[PUM_PIN_DMA_REQ_ONE] == PUM_FN_ALT) ?
			pin_in[PUM_PIN_DMA_REQ_ONE] : 1'b1; // see R15
		nxt_st.periph.dreq_n[0] = (fn[PUM_PIN_DMA_REQ_ZERO] == PUM_FN_ALT) ?
			pin_in[PUM_PIN_DMA_REQ_ZERO] : 1'b1; // see R15
		for (int k = 0; k < 8; k++) begin
			nxt_st.periph.irq_n[k] = (fn[k] == PUM_FN_ALT) ?
				pin_in[k] : 1'b1;
		end
	end

	// -------------------------------------------------------------
	// registers
	// -------------------------------------------------------------
	// only power-on reset clears; other resets never reach this block
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_ff <= PUM_STATE_RESET; // see R4 see R5
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	assign reg_rdata = st_ff.rdata;
	assign dbus_in   = st_ff.dbus_in;
	assign periph_in = st_ff.periph;
	assign pin_out   = st_ff.pin_out;
	assign pin_oe_n  = st_ff.pin_oe_n;

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	property p_sel_one_write;
		reg_req.wr && reg_req.addr == PUM_OFS_SEL_ONE
		|=> st_ff.sel_one == $past(reg_req.wdata);
	endproperty
	a_sel_one_write: assert property (p_sel_one_write) // see R1
		else $error("select one did not take the written value");

	property p_sel_two_read;
		reg_req.rd && reg_req.addr == PUM_OFS_SEL_TWO
		|=> reg_rdata == st_ff.sel_two;
	endproperty
	a_sel_two_read: assert property (p_sel_two_read) // see R2
		else $error("select two read back wrong");

	property p_romless_bus;
		PINS_PRESENT && romless_cs0_32 && dbus_drive
		|=> pin_oe_n == 16'h0000 && pin_out == $past(dbus_out);
	endproperty
	a_romless_bus: assert property (p_romless_bus) // see R10
		else $error("rom-less mode did not force the data bus");

	property p_single_no_bus;
		single_chip && !romless_cs0_32 |=> eff_is_dbus == 16'h0000;
	endproperty
	a_single_no_bus: assert property (p_single_no_bus) // see R9
		else $error("data bus selected in single-chip mode");

	property p_trig_route;
		PINS_PRESENT && !romless_cs0_32 && cfg[31:30] == PUM_MD_ALT
		|=> periph_in.trig_n == $past(pin_in[PUM_PIN_TRIG]);
	endproperty
	a_trig_route: assert property (p_trig_route) // see R11
		else $error("conversion trigger not routed from pin 31");

	property p_irqack_single;
		PINS_PRESENT && single_chip && !romless_cs0_32 &&
		cfg[29:28] == PUM_MD_ALT
		|=> st_ff.eff[29:28] == PUM_MD_GPIO &&
			pin_oe_n[PUM_PIN_IRQACK] == !$past(gpio_dir[PUM_PIN_IRQACK]);
	endproperty
	a_irqack_single: assert property (p_irqack_single) // see R12
		else $error("pin 30 alternate used in single-chip mode");

	property p_cs3_drive;
		PINS_PRESENT && !single_chip && !romless_cs0_32 &&
		cfg[27:26] == PUM_MD_ALT
		|=> !pin_oe_n[PUM_PIN_CS3] &&
			pin_out[PUM_PIN_CS3] == $past(alt_src.cs3_n);
	endproperty
	a_cs3_drive: assert property (p_cs3_drive) // see R13
		else $error("chip select three not driven on pin 29");

	property p_dma_ack_zero_drive;
		PINS_PRESENT && !single_chip && !romless_cs0_32 &&
		cfg[21:20] == PUM_MD_ALT
		|=> !pin_oe_n[PUM_PIN_DMA_ACK_ZERO] &&
			pin_out[PUM_PIN_DMA_ACK_ZERO] == $past(alt_src.dma_ack_zero_n);
	endproperty
	a_dma_ack_zero_drive: assert property (p_dma_ack_zero_drive) // see R14
		else $error("dma ack zero not driven on pin 26");

	property p_dreq_single;
		single_chip && !romless_cs0_32 && cfg[17:16] == PUM_MD_ALT
		|=> periph_in.dreq_n[0] == 1'b1 && st_ff.eff[17:16] == PUM_MD_GPIO;
	endproperty
	a_dreq_single: assert property (p_dreq_single) // see R15
		else $error("dma request zero routed in single-chip mode");

	property p_gpio_dir;
		resetn && !romless_cs0_32 && cfg[1:0] == PUM_MD_GPIO // not release edge
		|=> pin_oe_n[0] == !$past(gpio_dir[0]) &&
			pin_out[0] == $past(gpio_data_out[0]);
	endproperty
	a_gpio_dir: assert property (p_gpio_dir) // see R16
		else $error("general pin 16 ignored direction or data");

	property p_reserved_gpio;
		!romless_cs0_32 && cfg[3:2] == PUM_MD_RSVD
		|=> st_ff.eff[3:2] == PUM_MD_GPIO;
	endproperty
	a_reserved_gpio: assert property (p_reserved_gpio) // see R17
		else $error("reserved field not treated as general I/O");

	// read data must fall back to zero so stale words never linger
	property p_rdata_idle;
		!reg_req.rd |=> reg_rdata == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) // see R1
		else $error("read data not zero outside a read");

	property p_eff_one_read;
		reg_req.rd && reg_req.addr == PUM_OFS_EFF_ONE
		|=> reg_rdata == $past(st_ff.eff[31:16]);
	endproperty
	a_eff_one_read: assert property (p_eff_one_read) // see R3
		else $error("effective function readback wrong");

	property p_irqack_drive;
		PINS_PRESENT && !single_chip && !romless_cs0_32 &&
		cfg[29:28] == PUM_MD_ALT
		|=> !pin_oe_n[PUM_PIN_IRQACK] &&
			pin_out[PUM_PIN_IRQACK] == $past(alt_src.irq_accept_n);
	endproperty
	a_irqack_drive: assert property (p_irqack_drive) // see R12
		else $error("interrupt accepted not driven on pin 30");

	property p_dma_ack_one_drive;
		PINS_PRESENT && !single_chip && !romless_cs0_32 &&
		cfg[23:22] == PUM_MD_ALT
		|=> !pin_oe_n[PUM_PIN_DMA_ACK_ONE] &&
			pin_out[PUM_PIN_DMA_ACK_ONE] == $past(alt_src.dma_ack_one_n);
	endproperty
	a_dma_ack_one_drive: assert property (p_dma_ack_one_drive) // see R14
		else $error("dma ack one not driven on pin 27");

	property p_dreq_route;
		PINS_PRESENT && !single_chip && !romless_cs0_32 &&
		cfg[19:18] == PUM_MD_ALT
		|=> periph_in.dreq_n[1] == $past(pin_in[PUM_PIN_DMA_REQ_ONE]);
	endproperty
	a_dreq_route: assert property (p_dreq_route) // see R15
		else $error("dma request one not routed from pin 25");

	property p_irq_route;
		PINS_PRESENT && !romless_cs0_32 && cfg[15:14] == PUM_MD_ALT
		|=> periph_in.irq_n[7] == $past(pin_in[7]);
	endproperty
	a_irq_route: assert property (p_irq_route) // see R2
		else $error("interrupt input seven not routed from pin 23");

	// trigger pin is an input, so the pad must stay released
	property p_trig_hiz;
		PINS_PRESENT && !romless_cs0_32 && cfg[31:30] == PUM_MD_ALT
		|=> pin_oe_n[PUM_PIN_TRIG];
	endproperty
	a_trig_hiz: assert property (p_trig_hiz) // see R11
		else $error("pin 31 driven while it is the trigger input");

	property p_dbus_in;
		resetn |=> dbus_in == $past(pin_in);
	endproperty
	a_dbus_in: assert property (p_dbus_in) // see R9
		else $error("data bus input does not follow the pins");

	property p_trig_alt_seen;
		!romless_cs0_32 && cfg[31:30] == PUM_MD_ALT;
	endproperty
	c_trig_alt_seen: cover property (p_trig_alt_seen);

	property p_romless_seen;
		romless_cs0_32 && dbus_drive;
	endproperty
	c_romless_seen: cover property (p_romless_seen);

	property p_write_then_read;
		reg_req.wr && reg_req.addr == PUM_OFS_SEL_ONE
		##1 reg_req.rd && reg_req.addr == PUM_OFS_SEL_ONE;
	endproperty
	c_write_then_read: cover property (p_write_then_read);

	property p_single_alt_seen;
		single_chip && cfg[29:28] == PUM_MD_ALT;
	endproperty
	c_single_alt_seen: cover property (p_single_alt_seen);

	property p_reserved_seen;
		cfg[3:2] == PUM_MD_RSVD;
	endproperty
	c_reserved_seen: cover property (p_reserved_seen);

endmodule

// ### sim/pum_pad_model.sv
// pad ring model closing the loop from pin outputs to pin inputs
// assumes low pin_oe_n means the block drives the pad

module pum_pad_model
	import pum_pkg::*;
(
	// block side
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe_n,
	// board side level on undriven pads
	input  wire logic [15:0] ext_level,
	output logic [15:0]      pin_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// driven pads echo the block, released ones show the board
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule

// ### sim/pum_pin_select_tb_top.sv
// testbench for the upper port pin function select
// assumes the pad model closes the pin loop; one 25 MHz clock

module pum_pin_select_tb_top
	import pum_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ----
	// stimulus and observed signals
	// ----
	logic           clk_sys = 1'b0;
	logic           resetn  = 1'b0;
	pum_bus_req_t   req     = '0;
	logic [15:0]    rdata;
	logic           sc      = 1'b0;
	logic           rl      = 1'b0;
	logic [15:0]    dir     = 16'h0FF0;
	logic [15:0]    gdo     = 16'hA5A5;
	logic [15:0]    dbo     = 16'h3C3C;
	logic           drv     = 1'b1;
	logic [15:0]    dbi;
	pum_alt_src_t   alt     = 5'h15;
	pum_periph_in_t per;
	logic [15:0]    pin_in;
	logic [15:0]    pin_out;
	logic [15:0]    oe_n;
	logic [15:0]    ext     = 16'h0000;
	int             err_total = 0;
	int             checks    = 0;
	int             cyc       = 0;

	always #20 clk_sys = ~clk_sys;

	pum_pin_select u_dut (.clk_sys(clk_sys), .resetn(resetn),
		.reg_req(req), .reg_rdata(rdata), .single_chip(sc),
		.romless_cs0_32(rl), .gpio_dir(dir), .gpio_data_out(gdo),
		.dbus_out(dbo), .dbus_drive(drv), .dbus_in(dbi),
		.alt_src(alt), .periph_in(per), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(oe_n));

	pum_pad_model u_pads (.pin_out(pin_out), .pin_oe_n(oe_n),
		.ext_level(ext), .pin_in(pin_in));

	// ----
	// access tasks
	// ----
	task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge clk_sys);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		req <= '0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(logic [3:0] a, logic [15:0] exp);
		@(posedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk_sys);
		req <= '0;
		#1 chk("reg_rdata", rdata, exp);
	endtask

	// outputs are registered, so let two edges pass first
	task automatic pins(logic [15:0] m, logic [15:0] eo, logic [15:0] eoe);
		repeat (2) @(posedge clk_sys);
		#1 chk("pin_out", pin_out & m, eo);
		chk("pin_oe_n", oe_n, eoe);
	endtask

	task automatic print_verdict;
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// hang guard, far above the some fifty cycles needed
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			print_verdict();
		end
	end

	// ----
	// test sequence
	// ----
	initial begin
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(PUM_OFS_SEL_ONE, 16'h0000);
		rd(PUM_OFS_SEL_TWO, 16'h0000);
		rd(4'h8, 16'h0000);
		pins(16'hFFFF, 16'hA5A5, 16'hF00F);
		chk("periph_in", {5'h00, per}, 16'h07FF);
		// dbus fields high, reserved fields low
		wr(PUM_OFS_SEL_ONE, 16'h5555);
		wr(PUM_OFS_SEL_TWO, 16'hFFFF);
		rd(PUM_OFS_SEL_ONE, 16'h5555);
		rd(PUM_OFS_SEL_TWO, 16'hFFFF);
		rd(PUM_OFS_EFF_ONE, 16'h5555);
		rd(PUM_OFS_EFF_TWO, 16'h0000);
		pins(16'hFFFF, 16'h3CA5, 16'h000F);
		sc <= 1'b1;
		pins(16'hFFFF, 16'hA5A5, 16'hF00F);
		// all upper eight pins on alternate functions
		sc <= 1'b0;
		wr(PUM_OFS_SEL_ONE, 16'hAAAA);
		wr(PUM_OFS_SEL_TWO, 16'h0000);
		pins(16'h7C00, 16'h5400, 16'h830F);
		chk("periph_in", {5'h00, per}, 16'h00FF);
		sc <= 1'b1;
		pins(16'h7C00, 16'h2400, 16'hF00F);
		chk("periph_in", {5'h00, per}, 16'h03FF);
		// rom-less wide area overrides every field
		rl <= 1'b1;
		pins(16'hFFFF, 16'h3C3C, 16'h0000);
		drv <= 1'b0;
		pins(16'hFFFF, 16'h3C3C, 16'hFFFF);
		// interrupt inputs on the lower eight pins
		rl <= 1'b0;
		sc <= 1'b0;
		ext <= 16'h005A;
		wr(PUM_OFS_SEL_ONE, 16'h0000);
		wr(PUM_OFS_SEL_TWO, 16'hAAAA);
		pins(16'hFFFF, 16'hA5FF, 16'hF0FF);
		chk("periph_in", {5'h00, per}, 16'h075A);
		chk("dbus_in", dbi, 16'h055A);
		rd(PUM_OFS_SEL_TWO, 16'hAAAA);
		print_verdict();
	end
endmodule
